// ### adc_link_pkg.sv
/*
 Shared constants and types for the serial converter link and its host.
 Assumes both ends and the bench compile this package first.
*/
package adc_link_pkg;
	// ----------------------------------------------------------------
	// Word framing
	// ----------------------------------------------------------------
	localparam int WORD_BITS      = 24;
	localparam int BYTE_BITS      = 8;
	localparam int BYTES_PER_WORD = 3;

	// ----------------------------------------------------------------
	// Timing counts, in clk_in cycles or link clock pulses
	// ----------------------------------------------------------------
	localparam int SCLK_HALF_CYCLES   = 4;  // Must be 3 or more
	localparam int FLUSH_PULSES       = 8;
	localparam int LINK_RST_CYCLES    = 32;
	localparam int DATA_READY_N_SETTLE_CYCLES = 8;

	// ----------------------------------------------------------------
	// Register fields and reset values
	// ----------------------------------------------------------------
	localparam int          CAL_READ_BIT = 0;
	localparam logic [23:0] CTRL_RESET   = 24'h00_0000;
	localparam logic [23:0] CALIB_RESET  = 24'h00_0000;

	// Host commands
	typedef enum logic [2:0] {
		CMD_READ_DATA,
		CMD_READ_CTRL,
		CMD_READ_CALIB,
		CMD_WRITE_CTRL,
		CMD_WRITE_CALIB
	} cmd_e;
endpackage : adc_link_pkg

// ### adc_link_if.sv
/*
 Pins of the serial link between converter and host.
 Assumes the host drives the link clock and the bench joins the ends.
*/
`timescale 1ns/1ps
interface adc_link_if;
	logic sclk;
	logic receive_frame_n;
	logic transmit_frame_n;
	logic register_select;
	logic data_ready_n;
	logic dev_data_out;
	logic dev_data_oe;
	logic host_data_out;
	logic host_data_oe;
	logic sdata;

	// Shared data wire, pulled high when nobody drives
	assign sdata = dev_data_oe ? dev_data_out :
		(host_data_oe ? host_data_out : 1'b1);

	modport device (
		input  sclk, receive_frame_n, transmit_frame_n, register_select,
		input  sdata,
		output data_ready_n, dev_data_out, dev_data_oe
	);
	modport host (
		output sclk, receive_frame_n, transmit_frame_n, register_select,
		output host_data_out, host_data_oe,
		input  sdata, data_ready_n
	);
endinterface : adc_link_if

// ### word_fifo.sv
/*
 Small synchronous FIFO with valid/ready on both sides.
 Assumes DEPTH is a power of two and one clock for both sides.
*/
`timescale 1ns/1ps
module word_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 8
) (
	input  wire logic             clk_in,
	input  wire logic             rst_in,
	input  wire logic             in_valid_in,
	input  wire logic [WIDTH-1:0] in_data_in,
	output logic                  in_ready_out,
	output logic                  out_valid_out,
	input  wire logic             out_ready_in,
	output logic [WIDTH-1:0]      out_data_out
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW:0]      count_reg;

	// Honest flags from the fill count
	wire push = in_valid_in & in_ready_out;
	wire pop  = out_valid_out & out_ready_in;
	assign in_ready_out  = (count_reg != FULL);
	assign out_valid_out = (count_reg != '0);
	assign out_data_out  = mem[rd_ptr_reg];

	// Pointers wrap by overflow, hence the power-of-two depth
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else begin
			wr_ptr_reg <= wr_ptr_reg + AW'(push);
			rd_ptr_reg <= rd_ptr_reg + AW'(pop);
			count_reg  <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	// Storage has no reset; empty flag hides stale words
	always_ff @(posedge clk_in) begin
		if (push) begin
			mem[wr_ptr_reg] <= in_data_in;
		end
	end
endmodule : word_fifo

// ### adc_serial_device.sv
/*
 Converter end of the serial link: output, control and calibration words.
 Assumes the host gives flush pulses on the link clock after reset.
*/
`timescale 1ns/1ps
module adc_serial_device (
	adc_link_if.device   link,
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	input  wire logic [23:0] result_in,
	input  wire logic        result_valid_in,
	output logic             result_taken_out,
	output logic [23:0]      ctrl_out,
	output logic             ctrl_update_out
);
	localparam int W   = adc_link_pkg::WORD_BITS;
	localparam int CW  = $clog2(W);
	localparam int LRW = $clog2(adc_link_pkg::LINK_RST_CYCLES + 1);
	localparam logic [CW-1:0]  BIT_LAST = CW'(W - 1);
	localparam logic [LRW-1:0] LRST_CNT = LRW'(adc_link_pkg::LINK_RST_CYCLES);

	// ----------------------------------------------------------------
	// User clock domain
	// ----------------------------------------------------------------
	logic [LRW-1:0] lrst_cnt_reg;
	logic [W-1:0]   out_word_reg;
	logic           pending_reg;
	logic           done_s1_reg, done_s2_reg, done_s3_reg;
	logic           wr_s1_reg, wr_s2_reg, wr_s3_reg;
	logic [W-1:0]   ctrl_link_reg;
	logic [W-1:0]   calib_link_reg;
	logic           done_tgl_reg;
	logic           wr_tgl_reg;

	// A new result only replaces a word nobody is waiting on
	wire done_pulse   = done_s2_reg ^ done_s3_reg;
	wire ctrl_pulse   = wr_s2_reg ^ wr_s3_reg;
	wire load         = result_valid_in & (~pending_reg | done_pulse);
	wire pending_next = load | (pending_reg & ~done_pulse); // Set wins
	wire link_rst_req = (lrst_cnt_reg != '0);

	// Ready flag low while a fresh result waits
	assign link.data_ready_n = ~pending_reg;

	// Load, flag and crossing flops
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			lrst_cnt_reg     <= LRST_CNT;
			out_word_reg     <= '0;
			pending_reg      <= 1'b0;
			result_taken_out <= 1'b0;
			ctrl_out         <= adc_link_pkg::CTRL_RESET;
			ctrl_update_out  <= 1'b0;
		end else begin
			lrst_cnt_reg     <= lrst_cnt_reg - LRW'(link_rst_req);
			pending_reg      <= pending_next;
			result_taken_out <= load;
			ctrl_update_out  <= ctrl_pulse;
			if (load) begin
				out_word_reg <= result_in;
			end
			if (ctrl_pulse) begin
				ctrl_out <= ctrl_link_reg; // Stable for 24 pulses
			end
		end
	end

	// Toggle synchronisers from the link domain
	always_ff @(posedge clk_in) begin
		done_s1_reg <= done_tgl_reg;
		done_s2_reg <= done_s1_reg;
		done_s3_reg <= done_s2_reg;
		wr_s1_reg   <= wr_tgl_reg;
		wr_s2_reg   <= wr_s1_reg;
		wr_s3_reg   <= wr_s2_reg;
	end

	// ----------------------------------------------------------------
	// Link clock domain
	// ----------------------------------------------------------------
	logic          lrst_s1_reg, lrst_s2_reg;
	logic [CW-1:0] rd_cnt_reg;
	logic [CW-1:0] wr_cnt_reg;
	logic [W-1:0]  wr_shift_reg;

	// Select steers to control or output/calibration
	wire          cal_sel   = ctrl_link_reg[adc_link_pkg::CAL_READ_BIT];
	wire [W-1:0]  data_word = cal_sel ? calib_link_reg : out_word_reg;
	wire [W-1:0]  read_word = link.register_select ? data_word
		: ctrl_link_reg;
	wire          reading   = ~link.receive_frame_n;
	wire          writing   = ~link.transmit_frame_n;
	wire          rd_last   = (rd_cnt_reg == BIT_LAST);
	wire          wr_last   = (wr_cnt_reg == BIT_LAST);
	wire [W-1:0]  wr_word   = {wr_shift_reg[W-2:0], link.sdata};
	wire          out_done  = reading & rd_last & link.register_select
		& ~cal_sel;

	// Bit under the counter, MSB first
	assign link.dev_data_out = read_word[BIT_LAST - rd_cnt_reg];
	assign link.dev_data_oe  = reading;

	// Reset request reaches the link domain through two flops
	always_ff @(posedge link.sclk) begin
		lrst_s1_reg <= link_rst_req;
		lrst_s2_reg <= lrst_s1_reg;
	end

	// Counters survive frame gaps so a word spans transfers
	always_ff @(posedge link.sclk) begin
		if (lrst_s2_reg) begin
			rd_cnt_reg     <= '0;
			wr_cnt_reg     <= '0;
			wr_shift_reg   <= '0;
			ctrl_link_reg  <= adc_link_pkg::CTRL_RESET;
			calib_link_reg <= adc_link_pkg::CALIB_RESET;
			done_tgl_reg   <= 1'b0;
			wr_tgl_reg     <= 1'b0;
		end else begin
			if (reading) begin
				rd_cnt_reg <= rd_last ? '0 : rd_cnt_reg + 1'b1;
			end
			done_tgl_reg <= done_tgl_reg ^ out_done;
			if (writing) begin
				wr_cnt_reg   <= wr_last ? '0 : wr_cnt_reg + 1'b1;
				wr_shift_reg <= wr_word;
			end
			// Low select lands in control
			if (writing & wr_last & ~link.register_select) begin
				ctrl_link_reg <= wr_word;
				wr_tgl_reg    <= ~wr_tgl_reg;
			end
			if (writing & wr_last & link.register_select) begin
				calib_link_reg <= wr_word;
			end
		end
	end
endmodule : adc_serial_device

// ### adc_serial_host.sv
/*
 Host end of the serial converter link: makes the link clock, frames
 bytes and collects read words into a FIFO.
 Assumes the converter end samples on rising link clock edges.
*/
`timescale 1ns/1ps
// Notes on behaviour
// - Tied select wiring: writes reach control register
// - Tied wiring: reads return output or calibration
// - Tied wiring: control readback impossible, refused
// - Transmit frame may follow inverted receive frame
// - Wait for data ready low before reading
// - Output word may span several byte transfers
// - Control/calibration reads ignore data ready
// - Control read: select low with receive frame
// - Converter sends every word MSB first
// - First written bit is the MSB
// - Register write is one 24-bit word
// - LSB-first port reverses bits per byte
// - Frames and select idle high
// - Three bytes per word, recheck ready each
// - Data ready low on result, high after read
// - Select low control, high output/calibration
// - Control/calibration reads take full 24 bits
module adc_serial_host #(
	parameter bit SELECT_TIED    = 1'b0,
	parameter bit BYTE_LSB_FIRST = 1'b0,
	parameter int HALF_CYCLES    = adc_link_pkg::SCLK_HALF_CYCLES,
	parameter int FIFO_DEPTH     = 8
) (
	input  wire logic         clk_in,
	input  wire logic         rst_in,
	adc_link_if.host          link,
	input  wire logic         cmd_valid_in,
	output logic              cmd_ready_out,
	input  adc_link_pkg::cmd_e cmd_kind_in,
	input  wire logic [23:0]  cmd_wdata_in,
	output logic              cmd_refused_out,
	output logic              busy_out,
	output logic              rdata_valid_out,
	input  wire logic         rdata_ready_in,
	output logic [23:0]       rdata_out
);
	localparam int W  = adc_link_pkg::WORD_BITS;
	localparam int PW = $clog2(2 * HALF_CYCLES);
	localparam logic [PW-1:0] PH_SAMPLE = PW'(HALF_CYCLES - 1);
	localparam logic [PW-1:0] PH_HIGH   = PW'(HALF_CYCLES);
	localparam logic [PW-1:0] PH_LAST   = PW'(2 * HALF_CYCLES - 1);
	localparam logic [3:0] FLUSH_LAST  = 4'(adc_link_pkg::FLUSH_PULSES - 1);
	localparam logic [3:0] BIT_LAST    = 4'(adc_link_pkg::BYTE_BITS - 1);
	localparam logic [1:0] BYTE_LAST   = 2'(adc_link_pkg::BYTES_PER_WORD - 1);
	localparam logic [3:0] SETTLE_LAST =
		4'(adc_link_pkg::DATA_READY_N_SETTLE_CYCLES - 1);

	typedef enum logic [2:0] {
		ST_FLUSH, ST_IDLE, ST_WAIT_READY, ST_BYTE, ST_PUSH, ST_SETTLE
	} state_e;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Byte reversal for a port that shifts LSB first
	function automatic logic [7:0] port_order(input logic [7:0] b);
		logic [7:0] r;
		r = b;
		if (BYTE_LSB_FIRST) begin
			for (int i = 0; i < 8; i++) begin
				r[i] = b[7-i];
			end
		end
		return r;
	endfunction : port_order

	function automatic logic is_read(input adc_link_pkg::cmd_e k);
		return (k == adc_link_pkg::CMD_READ_DATA) |
			(k == adc_link_pkg::CMD_READ_CTRL) |
			(k == adc_link_pkg::CMD_READ_CALIB);
	endfunction : is_read

	// Select high for output and calibration words
	function automatic logic select_of(input adc_link_pkg::cmd_e k);
		return (k != adc_link_pkg::CMD_READ_CTRL) &
			(k != adc_link_pkg::CMD_WRITE_CTRL);
	endfunction : select_of

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	state_e             state_reg, state_next;
	adc_link_pkg::cmd_e kind_reg, kind_next;
	logic [PW-1:0]      phase_reg, phase_next;
	logic [3:0]         bit_cnt_reg, bit_cnt_next;
	logic [1:0]         byte_idx_reg, byte_idx_next;
	logic [W-1:0]       word_reg, word_next;
	logic [7:0]         tx_reg, tx_next;
	logic [7:0]         rx_reg, rx_next;
	logic               rfs_reg, rfs_next;
	logic               tfs_reg, tfs_next;
	logic               sel_reg, sel_next;
	logic               sclk_reg;
	logic               data_ready_n_s1_reg, data_ready_n_s2_reg;
	logic               sdata_s1_reg, sdata_s2_reg;
	logic               fifo_in_ready;

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	wire period_end  = (phase_reg == PH_LAST);
	wire sample_now  = (phase_reg == PH_SAMPLE);
	wire [PW-1:0] phase_step = period_end ? '0 : phase_reg + 1'b1;
	wire kind_read   = is_read(kind_reg);
	wire needs_ready = (kind_reg == adc_link_pkg::CMD_READ_DATA);
	wire cmd_read    = is_read(cmd_kind_in);
	// Tied wiring cannot reach these targets
	wire cmd_bad     = SELECT_TIED &
		((cmd_kind_in == adc_link_pkg::CMD_READ_CTRL) |
		(cmd_kind_in == adc_link_pkg::CMD_WRITE_CALIB));
	// A read is only taken when its word has a slot waiting
	assign cmd_ready_out = (state_reg == ST_IDLE) & (fifo_in_ready | ~cmd_read);
	wire cmd_take    = cmd_valid_in & cmd_ready_out;
	wire cmd_start   = cmd_take & ~cmd_bad;
	wire tx_bit      = BYTE_LSB_FIRST ? tx_reg[0] : tx_reg[7];
	wire [7:0] tx_shifted = BYTE_LSB_FIRST ? {1'b0, tx_reg[7:1]}
		: {tx_reg[6:0], 1'b0};
	wire [7:0] rx_shifted = BYTE_LSB_FIRST ? {sdata_s2_reg, rx_reg[7:1]}
		: {rx_reg[6:0], sdata_s2_reg};
	wire [7:0] rx_byte    = port_order(rx_reg);
	wire clock_run_next   = (state_next == ST_FLUSH) | (state_next == ST_BYTE);

	// ----------------------------------------------------------------
	// Transfer sequencer
	// ----------------------------------------------------------------
	always_comb begin
		state_next    = state_reg;
		kind_next     = kind_reg;
		phase_next    = '0;
		bit_cnt_next  = bit_cnt_reg;
		byte_idx_next = byte_idx_reg;
		word_next     = word_reg;
		tx_next       = tx_reg;
		rx_next       = rx_reg;
		rfs_next      = rfs_reg;
		tfs_next      = tfs_reg;
		sel_next      = sel_reg;
		case (state_reg)
			ST_FLUSH: begin
				phase_next = phase_step;
				if (period_end) begin
					bit_cnt_next = bit_cnt_reg + 1'b1;
					if (bit_cnt_reg == FLUSH_LAST) begin
						bit_cnt_next = '0;
						state_next   = ST_IDLE;
					end
				end
			end
			ST_IDLE: begin
				if (cmd_start) begin
					kind_next     = cmd_kind_in;
					word_next     = cmd_wdata_in;
					byte_idx_next = '0;
					bit_cnt_next  = '0;
					sel_next      = select_of(cmd_kind_in);
					tx_next       = port_order(cmd_wdata_in[W-1 -: 8]);
					if (cmd_kind_in == adc_link_pkg::CMD_READ_DATA) begin
						state_next = ST_WAIT_READY;
					end else if (cmd_read) begin
						rfs_next   = 1'b0;
						state_next = ST_BYTE;
					end else begin
						tfs_next   = 1'b0;
						state_next = ST_BYTE;
					end
				end
			end
			ST_WAIT_READY: begin
				// Ready is checked again before every byte
				if (!data_ready_n_s2_reg) begin
					rfs_next   = 1'b0;
					state_next = ST_BYTE;
				end
			end
			ST_BYTE: begin
				phase_next = phase_step;
				if (sample_now) begin
					rx_next = rx_shifted;
				end
				if (period_end && bit_cnt_reg != BIT_LAST) begin
					bit_cnt_next = bit_cnt_reg + 1'b1;
					tx_next      = tx_shifted;
				end else if (period_end) begin
					bit_cnt_next = '0;
					word_next    = {word_reg[W-9:0], rx_byte};
					if (byte_idx_reg == BYTE_LAST) begin
						// Full word done: both frames and select back high
						rfs_next   = 1'b1;
						tfs_next   = 1'b1;
						sel_next   = 1'b1;
						state_next = kind_read ? ST_PUSH : ST_IDLE;
					end else begin
						byte_idx_next = byte_idx_reg + 1'b1;
						tx_next       = port_order(word_reg[W-9 -: 8]);
						state_next    = needs_ready ? ST_WAIT_READY : ST_BYTE;
					end
				end
			end
			ST_PUSH: begin
				state_next = needs_ready ? ST_SETTLE : ST_IDLE;
			end
			ST_SETTLE: begin
				// Lets the released ready flag arrive before a new read
				bit_cnt_next = bit_cnt_reg + 1'b1;
				if (bit_cnt_reg == SETTLE_LAST) begin
					bit_cnt_next = '0;
					state_next   = ST_IDLE;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	// Sequencer registers; frames change only while the clock is low
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			state_reg <= ST_FLUSH;
			kind_reg  <= adc_link_pkg::CMD_READ_DATA;
			rfs_reg   <= 1'b1;
			tfs_reg   <= 1'b1;
			sel_reg   <= 1'b1;
			sclk_reg  <= 1'b0;
		end else begin
			state_reg <= state_next;
			kind_reg  <= kind_next;
			rfs_reg   <= rfs_next;
			tfs_reg   <= tfs_next;
			sel_reg   <= sel_next;
			sclk_reg  <= clock_run_next & (phase_next >= PH_HIGH);
		end
	end

	// Datapath and counters
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			phase_reg    <= '0;
			bit_cnt_reg  <= '0;
			byte_idx_reg <= '0;
			word_reg     <= '0;
			tx_reg       <= '0;
			rx_reg       <= '0;
		end else begin
			phase_reg    <= phase_next;
			bit_cnt_reg  <= bit_cnt_next;
			byte_idx_reg <= byte_idx_next;
			word_reg     <= word_next;
			tx_reg       <= tx_next;
			rx_reg       <= rx_next;
		end
	end

	// Pin synchronisers and refusal flag
	always_ff @(posedge clk_in) begin
		data_ready_n_s1_reg  <= link.data_ready_n;
		data_ready_n_s2_reg  <= data_ready_n_s1_reg;
		sdata_s1_reg <= link.sdata;
		sdata_s2_reg <= sdata_s1_reg;
		if (rst_in) begin
			cmd_refused_out <= 1'b0;
		end else begin
			cmd_refused_out <= cmd_take & cmd_bad;
		end
	end

	// ----------------------------------------------------------------
	// Pins and read buffer
	// ----------------------------------------------------------------
	assign link.sclk             = sclk_reg;
	// Receive frame is never built from the transmit one
	assign link.receive_frame_n  = rfs_reg;
	assign link.transmit_frame_n = tfs_reg;
	// Tied wiring: select follows transmit frame
	assign link.register_select  = SELECT_TIED ? tfs_reg : sel_reg;
	assign link.host_data_out    = tx_bit;
	assign link.host_data_oe     = ~tfs_reg;
	assign busy_out              = (state_reg != ST_IDLE);

	word_fifo #(
		.WIDTH (W),
		.DEPTH (FIFO_DEPTH)
	) read_buffer (
		.clk_in        (clk_in),
		.rst_in        (rst_in),
		.in_valid_in   (state_reg == ST_PUSH),
		.in_data_in    (word_reg),
		.in_ready_out  (fifo_in_ready),
		.out_valid_out (rdata_valid_out),
		.out_ready_in  (rdata_ready_in),
		.out_data_out  (rdata_out)
	);
endmodule : adc_serial_host

// ### adc_link_monitor.sv
/*
 Checker for the pins between converter end and host end.
 Assumes one clk_in domain; the link clock is sampled as a plain signal.
*/
`timescale 1ns/1ps
module adc_link_monitor (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic sclk,
	input wire logic receive_frame_n,
	input wire logic transmit_frame_n,
	input wire logic register_select,
	input wire logic dev_data_oe,
	input wire logic host_data_oe,
	input wire logic data_ready_n,
	input wire logic sdata
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	// ----------------------------------------------------------------
	// Idle and flush framing
	// ----------------------------------------------------------------
	sequence frames_idle_s;
		receive_frame_n && transmit_frame_n && register_select;
	endsequence
	sequence flush_s;
		frames_idle_s [*8];
	endsequence

	flush_idle_a: assert property ($fell(rst_in) |-> flush_s)
		else $error("frames not idle after reset");
	start_low_a: assert property ($fell(rst_in) |-> !sclk)
		else $error("link clock high after reset");
	// Frames may only move while the link clock rests low
	rfs_edge_a: assert property ($changed(receive_frame_n) |-> !sclk)
		else $error("read frame moved with clock high");
	tfs_edge_a: assert property ($changed(transmit_frame_n) |-> !sclk)
		else $error("write frame moved with clock high");
	sel_read_a: assert property (!receive_frame_n && !$past(receive_frame_n)
		|-> $stable(register_select))
		else $error("select moved in read frame");
	sel_write_a: assert property (!transmit_frame_n && !$past(transmit_frame_n)
		|-> $stable(register_select))
		else $error("select moved in write frame");
	one_frame_a: assert property (!(!receive_frame_n && !transmit_frame_n))
		else $error("both frames low");
	// Ready is only released by the read that empties the word
	ready_release_a: assert property ($rose(data_ready_n)
		|-> !$past(receive_frame_n))
		else $error("ready released outside a read frame");
	// Written bits move only while the link clock rests low
	wdata_move_a: assert property ($changed(sdata) && host_data_oe
		|-> !sclk)
		else $error("write data moved with clock high");
	// High phase lasts exactly four cycles at the default divider
	sclk_high_a: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
		else $error("link clock high phase wrong");
	ctrl_read_c: cover property (!receive_frame_n && !register_select);
endmodule : adc_link_monitor

// ### tb_adc_serial_host_interface.sv
/*
 Bench joining converter end and host end through the link interface.
 Assumes default package counts; the host makes the link clock.
*/
`timescale 1ns/1ps
module tb_adc_serial_host_interface;
	logic               clk_in, rst_in, cmd_valid_in, rdata_ready_in;
	logic               result_valid_in;
	logic [23:0]        cmd_wdata_in, result_in;
	adc_link_pkg::cmd_e cmd_kind_in;
	logic               cmd_ready_out, cmd_refused_out, busy_out;
	logic               rdata_valid_out, result_taken_out, ctrl_update_out;
	logic [23:0]        rdata_out, ctrl_out;
	int                 err_total, n_checks;
	logic               t_refused, t_valid;
	logic [23:0]        t_rdata, t_ctrl;
	int                 n_updates = 0, n_refused = 0, n_refused_main = 0;

	adc_link_if link ();
	adc_serial_device i_adc_serial_device (.link(link), .clk_in(clk_in),
		.rst_in(rst_in), .result_in(result_in),
		.result_valid_in(result_valid_in),
		.result_taken_out(result_taken_out), .ctrl_out(ctrl_out),
		.ctrl_update_out(ctrl_update_out));
	adc_serial_host i_adc_serial_host (.clk_in(clk_in), .rst_in(rst_in),
		.link(link), .cmd_valid_in(cmd_valid_in),
		.cmd_ready_out(cmd_ready_out), .cmd_kind_in(cmd_kind_in),
		.cmd_wdata_in(cmd_wdata_in), .cmd_refused_out(cmd_refused_out),
		.busy_out(busy_out), .rdata_valid_out(rdata_valid_out),
		.rdata_ready_in(rdata_ready_in), .rdata_out(rdata_out));
	adc_link_monitor i_adc_link_monitor (.clk_in(clk_in), .rst_in(rst_in),
		.sclk(link.sclk), .receive_frame_n(link.receive_frame_n),
		.transmit_frame_n(link.transmit_frame_n),
		.register_select(link.register_select),
		.dev_data_oe(link.dev_data_oe), .host_data_oe(link.host_data_oe),
		.data_ready_n(link.data_ready_n), .sdata(link.sdata));

	// Tied select wiring and LSB-first port, same commands in lockstep
	adc_link_if tied_link ();
	adc_serial_device i_adc_serial_device_tied (.link(tied_link),
		.clk_in(clk_in), .rst_in(rst_in), .result_in(result_in),
		.result_valid_in(result_valid_in), .result_taken_out(),
		.ctrl_out(t_ctrl), .ctrl_update_out());
	adc_serial_host #(.SELECT_TIED(1'b1), .BYTE_LSB_FIRST(1'b1))
		i_adc_serial_host_tied (.clk_in(clk_in), .rst_in(rst_in),
		.link(tied_link), .cmd_valid_in(cmd_valid_in), .cmd_ready_out(),
		.cmd_kind_in(cmd_kind_in), .cmd_wdata_in(cmd_wdata_in),
		.cmd_refused_out(t_refused), .busy_out(),
		.rdata_valid_out(t_valid), .rdata_ready_in(rdata_ready_in),
		.rdata_out(t_rdata));

	// Pulse counters; the pulses end before a polling wait returns
	always @(negedge clk_in) begin
		if (ctrl_update_out === 1'b1) n_updates++;
		if (cmd_refused_out === 1'b1) n_refused_main++;
		if (t_refused === 1'b1) n_refused++;
	end

	// ----------------------------------------------------------------
	// Checking and waiting helpers
	// ----------------------------------------------------------------
	task report_and_stop;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : report_and_stop

	task check(input logic [23:0] seen, input logic [23:0] exp,
		input string what);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch at %0t: %s %h vs %h", $time, what, seen, exp);
		end
	endtask : check

	// Conditions polled at the falling edge, where outputs are settled
	function automatic logic cond(input int sel);
		case (sel)
			0: cond = (busy_out === 1'b0);
			1: cond = (rdata_valid_out === 1'b1);
			2: cond = (link.data_ready_n === 1'b0);
			3: cond = (link.data_ready_n === 1'b1);
			5: cond = (result_taken_out === 1'b1);
			default: cond = (cmd_ready_out === 1'b1);
		endcase
	endfunction : cond

	// Bounded wait; running out of time closes the run
	task wait_on(input int sel);
		int n;
		n = 0;
		do begin
			@(negedge clk_in);
			n++;
			if (n > 4000) begin
				err_total++;
				$display("mismatch at %0t: wait %0d timed out", $time, sel);
				report_and_stop();
			end
		end while (!cond(sel));
	endtask : wait_on

	// Command stays up until the edge that sees ready high
	task issue(input adc_link_pkg::cmd_e k, input logic [23:0] d);
		wait_on(6);
		@(posedge clk_in);
		cmd_valid_in <= 1'b1;
		cmd_kind_in  <= k;
		cmd_wdata_in <= d;
		wait_on(6);
		@(posedge clk_in);
		cmd_valid_in <= 1'b0;
		wait_on(0);
	endtask : issue

	task pop(input logic [23:0] exp);
		wait_on(1);
		check(rdata_out, exp, "read word");
		@(posedge clk_in);
		rdata_ready_in <= 1'b1;
		@(posedge clk_in);
		rdata_ready_in <= 1'b0;
	endtask : pop

	initial begin
		clk_in = 1'b0;
		forever #20 clk_in = ~clk_in;
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		rst_in = 1'b1;
		cmd_valid_in = 1'b0;
		rdata_ready_in = 1'b0;
		result_valid_in = 1'b0;
		result_in = 24'h00_0000;
		cmd_wdata_in = 24'h00_0000;
		cmd_kind_in = adc_link_pkg::CMD_READ_DATA;
		err_total = 0;
		n_checks = 0;
		repeat (20) @(posedge clk_in);
		rst_in <= 1'b0;
		wait_on(6);
		check(ctrl_out, adc_link_pkg::CTRL_RESET, "ctrl reset");
		check({23'h0, link.data_ready_n}, 24'h00_0001, "ready idle");
		issue(adc_link_pkg::CMD_READ_CTRL, 24'h00_0000);
		pop(adc_link_pkg::CTRL_RESET);
		$display("test reset_values done");

		// Control write, readback, then calibration path via bit 0
		issue(adc_link_pkg::CMD_WRITE_CTRL, 24'hA5_3C_0F);
		check(ctrl_out, 24'hA5_3C_0F, "ctrl written");
		check(24'(n_updates), 24'h00_0001, "ctrl pulses");
		check(t_ctrl, 24'hA5_3C_0F, "tied ctrl written");
		issue(adc_link_pkg::CMD_READ_CTRL, 24'h00_0000);
		pop(24'hA5_3C_0F);
		issue(adc_link_pkg::CMD_WRITE_CALIB, 24'h12_3456);
		check(ctrl_out, 24'hA5_3C_0F, "ctrl kept");
		check(24'(n_updates), 24'h00_0001, "calib no pulse");
		issue(adc_link_pkg::CMD_READ_CALIB, 24'h00_0000);
		wait_on(1);
		check(t_rdata, adc_link_pkg::CALIB_RESET, "tied calib");
		pop(24'h12_3456);
		issue(adc_link_pkg::CMD_WRITE_CTRL, 24'h5A_C3_F0);
		check(ctrl_out, 24'h5A_C3_F0, "ctrl rewritten");
		check(24'(n_updates), 24'h00_0002, "ctrl pulses 2");
		$display("test register_access done");

		// Output word: ready falls on load, rises after its last bit
		@(posedge clk_in);
		result_in <= 24'h81_7E_C3;
		result_valid_in <= 1'b1;
		wait_on(5);
		@(posedge clk_in);
		result_valid_in <= 1'b0;
		wait_on(2);
		issue(adc_link_pkg::CMD_READ_DATA, 24'h00_0000);
		wait_on(1);
		check(t_rdata, 24'h81_7E_C3, "tied data word");
		pop(24'h81_7E_C3);
		wait_on(3);
		check({23'h0, link.data_ready_n}, 24'h00_0001, "ready released");
		$display("test output_word done");

		// Fill the read buffer, reads then stall until drained
		for (int i = 0; i < 8; i++) issue(adc_link_pkg::CMD_READ_CTRL, 24'h00_0000);
		repeat (4) @(negedge clk_in);
		check({23'h0, cmd_ready_out}, 24'h00_0000, "full stalls reads");
		for (int i = 0; i < 8; i++) pop(24'h5A_C3_F0);
		wait_on(6);
		check({23'h0, rdata_valid_out}, 24'h00_0000, "buffer empty");
		$display("test buffer_fill done");

		// Tied host refused every control read and calibration write
		check({23'h0, t_valid}, 24'h00_0000, "tied empty");
		check(24'(n_refused), 24'h00_000B, "tied refusals");
		check(24'(n_refused_main), 24'h00_0000, "no refusals");
		check(t_ctrl, 24'h5A_C3_F0, "tied ctrl");
		$display("test tied_wiring done");
		report_and_stop();
	end
endmodule : tb_adc_serial_host_interface
